// file: design/apcl_pkg.sv
// apcl_pkg: offsets, field positions, codes and reset values of the bank
package apcl_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_POWER = 8'h15;
    localparam logic [7:0] IDX_CLKDIV = 8'h27;
    localparam logic [7:0] IDX_LINK = 8'h2a;
    localparam logic [7:0] IDX_OVR = 8'h2b;
    localparam logic [7:0] IDX_OPF = 8'h30;
    localparam logic [7:0] IDX_FPM = 8'h31;
    localparam logic [7:0] IDX_STATUS = 8'h3c;
    localparam logic [7:0] REG_RESET = 8'h00;
    // writable bits of each register; the rest read as zero
    localparam logic [7:0] MASK_POWER = 8'h6d;
    localparam logic [7:0] MASK_CLKDIV = 8'hc0;
    localparam logic [7:0] MASK_LINK = 8'hff;
    localparam logic [7:0] MASK_OVR = 8'h03;
    localparam logic [7:0] MASK_OPF = 8'hff;
    localparam logic [7:0] MASK_FPM = 8'h1f;
    // power control fields
    localparam int PWR_A_BIT = 6;
    localparam int PWR_B_BIT = 5;
    localparam int PWR_STBY_BIT = 3;
    localparam int PWR_GLOB_BIT = 2;
    localparam int PWR_IGN_BIT = 0;
    // divider select, bits 7-6
    localparam int DIV_LSB = 6;
    localparam logic [1:0] DIV_BYPASS = 2'b00;
    localparam logic [1:0] DIV_1 = 2'b01;
    localparam logic [1:0] DIV_2 = 2'b10;
    localparam logic [1:0] DIV_4 = 2'b11;
    // link test control fields
    localparam int LNK_PAT_LSB = 6;
    localparam int LNK_IDLE_BIT = 5;
    localparam int LNK_TRP_BIT = 4;
    localparam int LNK_FLIP_BIT = 3;
    localparam int LNK_LANE_BIT = 2;
    localparam int LNK_FRAME_BIT = 1;
    localparam int LNK_SKIP_BIT = 0;
    localparam logic [1:0] PAT_NORMAL = 2'b00;
    localparam logic [1:0] PAT_CLOCK = 2'b01;
    localparam logic [1:0] PAT_ENCODED = 2'b10;
    localparam logic [1:0] PAT_PRBS = 2'b11;
    // override fields
    localparam int OVR_K_BIT = 1;
    localparam int OVR_F_BIT = 0;
    localparam logic [7:0] OPF_20X = 8'h01;
    localparam logic [7:0] OPF_40X = 8'h03;
    localparam logic [2:0] DEF_F = 3'd2;
    localparam logic [2:0] WIDE_F = 3'd4;
    localparam logic [5:0] DEF_K = 6'd9;
    localparam logic [1:0] ILA_LAST_MF = 2'd3;
    // link octet codes
    localparam logic [7:0] K28_0 = 8'h1c;
    localparam logic [7:0] K28_3 = 8'h7c;
    localparam logic [7:0] K28_4 = 8'h9c;
    localparam logic [7:0] K28_5 = 8'hbc;
    localparam logic [7:0] K28_7 = 8'hfc;
    localparam logic [7:0] IDLE_ALT = 8'h50;
    localparam logic [7:0] CLOCK_OCTET = 8'haa;
    localparam logic [14:0] PRBS_SEED = 15'h7fff;
    typedef enum logic [1:0] {LNK_SYNC, LNK_ILA, LNK_DATA} apcl_link_t;
endpackage : apcl_pkg

// file: design/apcl_prbs_if.sv
// apcl_prbs_if: carrier between the lane framer and its prbs source
`timescale 1ns/1ps
interface apcl_prbs_if;
    logic advance;
    logic restart;
    logic [7:0] octet;
    modport src (input advance, input restart, output octet);
    modport snk (output advance, output restart, input octet);
endinterface : apcl_prbs_if

// file: design/apcl_prbs15.sv
// apcl_prbs15: 2^15-1 sequence, eight bits per step
`timescale 1ns/1ps
module apcl_prbs15
    import apcl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pattern carrier
    apcl_prbs_if.src pat
);
    logic [14:0] state;
    logic [22:0] stepped;

    // x^15 + x^14 + 1, unrolled eight times per call
    function automatic logic [22:0] step8(input logic [14:0] s);
        logic [14:0] v;
        logic [7:0] o;
        v = s;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = v[14] ^ v[13];
            v = {v[13:0], o[i]};
        end
        return {v, o};
    endfunction : step8

    assign stepped = step8(state);
    assign pat.octet = stepped[7:0];

    // seed on restart so the sequence starts cleanly on each selection
    always_ff @(posedge clk) begin
        if (rst || pat.restart) begin
            state <= PRBS_SEED;
        end else if (pat.advance) begin
            state <= stepped[22:8];
        end
    end
endmodule : apcl_prbs15

// file: design/apcl_config.sv
// apcl_config: configuration bank, power decisions and lane framer
`timescale 1ns/1ps
module apcl_config
    import apcl_pkg::*;
#(
    parameter logic [7:0] ENCODED_OCTET = 8'hb5
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    // power control
    input wire logic SLEEP_PIN,
    output logic CHA_SLEEP,
    output logic CHB_SLEEP,
    output logic ADC_STANDBY,
    output logic DEVICE_SLEEP,
    // sample clock
    output logic SAMPLE_EN,
    // sample data
    input wire logic [13:0] CHA_SAMPLE,
    input wire logic [13:0] CHB_SAMPLE,
    // link
    input wire logic SYNC_N,
    output logic [7:0] LANE_A_DATA,
    output logic LANE_A_K,
    output logic [7:0] LANE_B_DATA,
    output logic LANE_B_K,
    output logic LINK_DATA
);
    // configuration registers, stored already masked
    logic [7:0] power_down_control, sample_clock_divider;
    logic [7:0] serial_link_test_control, link_parameter_override;
    logic [7:0] octets_per_frame, frames_per_multiframe;

    // bus decode
    logic [7:0] idx, rd_val;
    logic hit, access, wr_en;

    // link state and counters
    apcl_link_t st;
    logic [2:0] oct_cnt, f_oct;
    logic [5:0] fr_cnt, k_fr;
    logic [1:0] mf_cnt, pattern, div_cnt;
    logic phase, last_oct, last_fr;
    logic [13:0] hold_a, hold_b;

    // shared octet choice
    logic use_data, next_k;
    logic [7:0] next_ctrl;
    logic [13:0] smp_a, smp_b;

    apcl_prbs_if prbs ();

    apcl_prbs15 u_prbs (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .pat(prbs.src)
    );

    // divider phases that must be zero for an enable pulse
    function automatic logic [1:0] div_mask(input logic [1:0] sel);
        logic [1:0] m;
        m = 2'b00;
        unique case (sel)
            DIV_BYPASS: m = 2'b00;
            DIV_1: m = 2'b00;
            DIV_2: m = 2'b01;
            DIV_4: m = 2'b11;
        endcase
        return m;
    endfunction : div_mask

    // sample after test and flip options, for one lane
    function automatic logic [13:0] lane_sample(
        input logic [13:0] raw,
        input logic lane_b,
        input logic trp,
        input logic flip,
        input logic [5:0] fr
    );
        logic [13:0] s;
        s = flip ? {<<{raw}} : raw; // msb and lsb swap places
        if (trp) begin
            s = {lane_b, ~lane_b, fr[3:0], 8'h00};
        end
        return s;
    endfunction : lane_sample

    // split a sample into the octets of one frame
    function automatic logic [7:0] data_octet(input logic [13:0] s,
                                              input logic [2:0] oct);
        logic [15:0] w;
        w = {s, 2'b00};
        return (oct == 3'd0) ? w[15:8] : (oct == 3'd1) ? w[7:0] : 8'h00;
    endfunction : data_octet

    // apb address decode and read mux
    assign idx = PADDR[9:2];
    assign access = PSEL && PENABLE;
    always_comb begin
        hit = (PADDR[11:10] == 2'b00) && (PADDR[1:0] == 2'b00);
        rd_val = 8'h00;
        case (idx)
            IDX_POWER: rd_val = power_down_control;
            IDX_CLKDIV: rd_val = sample_clock_divider;
            IDX_LINK: rd_val = serial_link_test_control;
            IDX_OVR: rd_val = link_parameter_override;
            IDX_OPF: rd_val = octets_per_frame;
            IDX_FPM: rd_val = frames_per_multiframe;
            IDX_STATUS: rd_val = {3'b000, LINK_DATA, CHA_SLEEP,
                                  CHB_SLEEP, ADC_STANDBY, DEVICE_SLEEP};
            default: hit = 1'b0;
        endcase
    end

    // one wait state: pready rises on the second access cycle
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (access && !PREADY) begin
            PREADY <= 1'b1;
            PRDATA <= (PWRITE || !hit) ? 32'h0000_0000
                                       : {24'h00_0000, rd_val};
            PSLVERR <= !hit;
        end else begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
    end

    // writes land only at the completing edge; status is read only
    assign wr_en = access && PREADY && PWRITE && PSTRB[0] && hit;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            power_down_control <= REG_RESET;
            sample_clock_divider <= REG_RESET;
            serial_link_test_control <= REG_RESET;
            link_parameter_override <= REG_RESET;
            octets_per_frame <= REG_RESET;
            frames_per_multiframe <= REG_RESET;
        end else if (wr_en) begin
            // reserved positions are dropped, never stored
            case (idx)
                IDX_POWER: power_down_control <= PWDATA[7:0] & MASK_POWER;
                IDX_CLKDIV: sample_clock_divider <= PWDATA[7:0] & MASK_CLKDIV;
                IDX_LINK: serial_link_test_control <= PWDATA[7:0] & MASK_LINK;
                IDX_OVR: link_parameter_override <= PWDATA[7:0] & MASK_OVR;
                IDX_OPF: octets_per_frame <= PWDATA[7:0] & MASK_OPF;
                IDX_FPM: frames_per_multiframe <= PWDATA[7:0] & MASK_FPM;
                default: ;
            endcase
        end
    end

    // power decisions; with the pin in charge both channels and device sleep follow it, standby keeps its bit
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            CHA_SLEEP <= 1'b0;
            CHB_SLEEP <= 1'b0;
            ADC_STANDBY <= 1'b0;
            DEVICE_SLEEP <= 1'b0;
        end else if (power_down_control[PWR_IGN_BIT]) begin
            CHA_SLEEP <= power_down_control[PWR_A_BIT]
                         | power_down_control[PWR_GLOB_BIT];
            CHB_SLEEP <= power_down_control[PWR_B_BIT]
                         | power_down_control[PWR_GLOB_BIT];
            ADC_STANDBY <= power_down_control[PWR_STBY_BIT];
            DEVICE_SLEEP <= power_down_control[PWR_GLOB_BIT];
        end else begin
            CHA_SLEEP <= SLEEP_PIN | power_down_control[PWR_GLOB_BIT];
            CHB_SLEEP <= SLEEP_PIN | power_down_control[PWR_GLOB_BIT];
            ADC_STANDBY <= power_down_control[PWR_STBY_BIT];
            DEVICE_SLEEP <= SLEEP_PIN | power_down_control[PWR_GLOB_BIT];
        end
    end

    // sample enable; bypass and divide-by-one both give every cycle
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            div_cnt <= 2'b00;
            SAMPLE_EN <= 1'b0;
        end else begin
            div_cnt <= div_cnt + 2'b01;
            SAMPLE_EN <= (div_cnt & div_mask(
                sample_clock_divider[DIV_LSB +: 2])) == 2'b00;
        end
    end

    // frame geometry; codes other than 40X fall back to two octets
    always_comb begin
        f_oct = DEF_F;
        if (link_parameter_override[OVR_F_BIT]) begin
            f_oct = (octets_per_frame == OPF_40X) ? WIDE_F : DEF_F;
        end
        k_fr = DEF_K;
        if (link_parameter_override[OVR_K_BIT]) begin
            k_fr = {1'b0, frames_per_multiframe[4:0]} + 6'd1;
        end
    end
    assign last_oct = oct_cnt == (f_oct - 3'd1);
    assign last_fr = fr_cnt == (k_fr - 6'd1);
    assign pattern = serial_link_test_control[LNK_PAT_LSB +: 2];

    // link sequencing; sync request always wins and restarts framing
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st <= LNK_SYNC;
        end else begin
            unique case (st)
                LNK_SYNC: begin
                    if (SYNC_N) begin
                        st <= serial_link_test_control[LNK_SKIP_BIT]
                              ? LNK_DATA : LNK_ILA;
                    end
                end
                LNK_ILA: begin
                    if (!SYNC_N) begin
                        st <= LNK_SYNC;
                    end else if (last_oct && last_fr
                                 && mf_cnt == ILA_LAST_MF) begin
                        st <= LNK_DATA;
                    end
                end
                LNK_DATA: begin
                    if (!SYNC_N) begin
                        st <= LNK_SYNC;
                    end
                end
            endcase
        end
    end

    // octet, frame and multiframe counters, held at zero during sync
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || st == LNK_SYNC || !SYNC_N) begin
            oct_cnt <= 3'd0;
            fr_cnt <= 6'd0;
            mf_cnt <= 2'd0;
        end else if (last_oct) begin
            oct_cnt <= 3'd0;
            if (last_fr) begin
                fr_cnt <= 6'd0;
                mf_cnt <= mf_cnt + 2'd1;
            end else begin
                fr_cnt <= fr_cnt + 6'd1;
            end
        end else begin
            oct_cnt <= oct_cnt + 3'd1;
        end
    end

    // idle code phase runs free so the two-octet code stays paired;
    // the divider counter already toggles its low bit every cycle
    assign phase = div_cnt[0];

    // capture samples once per frame so a frame never mixes two samples
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            hold_a <= 14'h0000;
            hold_b <= 14'h0000;
        end else if (last_oct) begin
            hold_a <= CHA_SAMPLE;
            hold_b <= CHB_SAMPLE;
        end
    end

    assign smp_a = lane_sample(hold_a, 1'b0,
                               serial_link_test_control[LNK_TRP_BIT],
                               serial_link_test_control[LNK_FLIP_BIT],
                               fr_cnt);
    assign smp_b = lane_sample(hold_b, 1'b1,
                               serial_link_test_control[LNK_TRP_BIT],
                               serial_link_test_control[LNK_FLIP_BIT],
                               fr_cnt);

    // prbs runs only while selected and restarts on every selection
    assign prbs.advance = pattern == PAT_PRBS;
    assign prbs.restart = pattern != PAT_PRBS;

    // octet kind shared by both lanes; test patterns override the link
    always_comb begin
        use_data = 1'b0;
        next_k = 1'b0;
        next_ctrl = 8'h00;
        if (pattern == PAT_CLOCK) begin
            next_ctrl = CLOCK_OCTET;
        end else if (pattern == PAT_ENCODED) begin
            next_ctrl = ENCODED_OCTET;
        end else if (pattern == PAT_PRBS) begin
            next_ctrl = prbs.octet;
        end else if (st == LNK_SYNC || !SYNC_N) begin
            next_k = !phase || !serial_link_test_control[LNK_IDLE_BIT];
            next_ctrl = next_k ? K28_5 : IDLE_ALT;
        end else if (st == LNK_ILA) begin
            next_k = 1'b1;
            if (oct_cnt == 3'd0 && fr_cnt == 6'd0) begin
                next_ctrl = K28_0;
            end else if (last_oct && last_fr) begin
                next_ctrl = K28_3;
            end else if (mf_cnt == 2'd1 && fr_cnt == 6'd0
                         && oct_cnt == 3'd1) begin
                next_ctrl = K28_4;
            end else begin
                next_k = 1'b0;
                next_ctrl = {fr_cnt[4:0], oct_cnt};
            end
        end else if (last_oct && last_fr
                     && serial_link_test_control[LNK_LANE_BIT]) begin
            next_k = 1'b1;
            next_ctrl = K28_3;
        end else if (last_oct
                     && serial_link_test_control[LNK_FRAME_BIT]) begin
            next_k = 1'b1;
            next_ctrl = K28_7;
        end else begin
            use_data = 1'b1;
        end
    end

    // registered lane outputs
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            LANE_A_DATA <= 8'h00;
            LANE_A_K <= 1'b0;
            LANE_B_DATA <= 8'h00;
            LANE_B_K <= 1'b0;
            LINK_DATA <= 1'b0;
        end else begin
            LANE_A_DATA <= use_data ? data_octet(smp_a, oct_cnt) : next_ctrl;
            LANE_A_K <= next_k;
            LANE_B_DATA <= use_data ? data_octet(smp_b, oct_cnt) : next_ctrl;
            LANE_B_K <= next_k;
            LINK_DATA <= st == LNK_DATA;
        end
    end
endmodule : apcl_config

// file: tb/apcl_config_assertions.sv
// apcl_config_assertions: port-level checks of the configuration bank
`timescale 1ns/1ps
module apcl_config_assertions
    import apcl_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // apb answer
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    // power and link
    input wire logic CHA_SLEEP,
    input wire logic CHB_SLEEP,
    input wire logic DEVICE_SLEEP,
    input wire logic SYNC_N,
    input wire logic LINK_DATA,
    input wire logic [7:0] LANE_A_DATA,
    input wire logic LANE_A_K,
    input wire logic [7:0] LANE_B_DATA,
    input wire logic LANE_B_K
);
    // single clock domain
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    a_one_wait: assert property (PSEL && PENABLE && !$past(PENABLE) |=> PREADY)
        else $error("ready late");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held");
    a_ready_cause: assert property (PREADY |-> $past(PSEL) && $past(PENABLE))
        else $error("ready without access");
    a_err_quiet: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error answer malformed");
    a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer");
    a_rdata_upper: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    a_global_both: assert property (DEVICE_SLEEP |-> CHA_SLEEP && CHB_SLEEP)
        else $error("global sleep left a channel up");
    a_sync_stops: assert property (!SYNC_N |-> ##2 !LINK_DATA)
        else $error("data phase during sync request");
    a_lane_a_kchar: assert property (LANE_A_K |-> LANE_A_DATA[4:0] == 5'h1c)
        else $error("lane a bad control char");
    a_lane_b_kchar: assert property (LANE_B_K |-> LANE_B_DATA[4:0] == 5'h1c)
        else $error("lane b bad control char");
endmodule : apcl_config_assertions

// file: tb/apcl_rx_model.sv
// apcl_rx_model: link receiver that requests sync and tallies align chars
`timescale 1ns/1ps
module apcl_rx_model
    import apcl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench permission to leave sync
    input wire logic go,
    // lane under watch
    input wire logic [7:0] lane_data,
    input wire logic lane_k,
    output logic sync_n,
    // tallies
    output int n_frame_char,
    output int n_lane_char
);
    int idle_run;

    // release only after four idle codes; go alone is not enough
    always_ff @(posedge clk) begin
        if (rst || !go) begin
            idle_run <= 0;
            sync_n <= 1'b0;
        end else begin
            if (lane_k && lane_data == K28_5 && idle_run < 4) begin
                idle_run <= idle_run + 1;
            end
            sync_n <= sync_n || (idle_run >= 4);
        end
    end

    // alignment characters seen on the lane
    always_ff @(posedge clk) begin
        if (rst) begin
            n_frame_char <= 0;
            n_lane_char <= 0;
        end else begin
            if (lane_k && lane_data == K28_7) begin
                n_frame_char <= n_frame_char + 1;
            end
            if (lane_k && lane_data == K28_3) begin
                n_lane_char <= n_lane_char + 1;
            end
        end
    end
endmodule : apcl_rx_model

// file: tb/testbench.sv
// testbench: register, power, clock and lane checks of the bank
`timescale 1ns/1ps
module testbench;
    import apcl_pkg::*;
    localparam logic [7:0] ENC = 8'h3c;
    logic CORE_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [3:0] PSTRB = 4'h1;
    logic SLEEP_PIN = 1'b0;
    logic [13:0] CHA_SAMPLE = 14'h0;
    logic [13:0] CHB_SAMPLE = 14'h0;
    logic go = 1'b0;
    logic PREADY, PSLVERR, CHA_SLEEP, CHB_SLEEP, ADC_STANDBY, DEVICE_SLEEP;
    logic SAMPLE_EN, SYNC_N, LANE_A_K, LANE_B_K, LINK_DATA, ev;
    logic [31:0] PRDATA, rv;
    logic [7:0] LANE_A_DATA, LANE_B_DATA;
    int n_fail = 0;
    int checks_done = 0;
    int n_fc, n_lc;
    logic [31:0] rng = 32'd44193;
    logic [7:0] mdl [0:255];
    logic [7:0] msk [0:255] = '{default: 8'h00};
    logic [7:0] msks [6] = '{MASK_POWER, MASK_CLKDIV, MASK_LINK, MASK_OVR,
        MASK_OPF, MASK_FPM};
    logic [7:0] regs [6] = '{IDX_POWER, IDX_CLKDIV, IDX_LINK, IDX_OVR,
        IDX_OPF, IDX_FPM};

    apcl_config #(.ENCODED_OCTET(ENC)) dut_u (.*);
    // far-side receiver on lane a
    apcl_rx_model rx_u (.clk(CORE_CLK), .rst(SYS_RST), .go(go),
        .lane_data(LANE_A_DATA), .lane_k(LANE_A_K), .sync_n(SYNC_N),
        .n_frame_char(n_fc), .n_lane_char(n_lc));

    // 40 mhz clock
    initial begin
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    // expected {cha, chb, standby, device}
    function automatic logic [3:0] pwr_exp(logic [7:0] p, logic pin);
        logic g = p[PWR_GLOB_BIT];
        if (p[PWR_IGN_BIT]) begin
            return {p[PWR_A_BIT] | g, p[PWR_B_BIT] | g, p[PWR_STBY_BIT], g};
        end
        return {pin | g, pin | g, p[PWR_STBY_BIT], pin | g};
    endfunction : pwr_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; waits for ready under a bound
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        int n;
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        rv = PRDATA;
        ev = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, {24'h0, d});
        if (PSTRB[0]) mdl[idx] = d & msk[idx];
        chk(ev, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] idx);
        apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
        chk(rv, {24'h0, mdl[idx]});
    endtask : rd

    // lane a octets in one of two forms
    task automatic lane_chk(input logic [7:0] m, input logic [7:0] hi,
                            input logic [7:0] lo);
        repeat (4) begin
            @(posedge CORE_CLK);
            chk(!LANE_A_K && ((LANE_A_DATA & m) == hi
                || LANE_A_DATA == lo), 1);
        end
    endtask : lane_chk

    // sync, ila, then cycles to data
    task automatic link_up(input logic [7:0] ovr, input logic [7:0] opf,
                           input logic [7:0] fpm, input logic [7:0] lk,
                           output int n);
        go <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        wr(IDX_OVR, ovr);
        wr(IDX_OPF, opf);
        wr(IDX_FPM, fpm);
        wr(IDX_LINK, lk);
        go <= 1'b1;
        n = 0;
        while (SYNC_N !== 1'b1 && n < 100) begin
            @(posedge CORE_CLK);
            n++;
        end
        n = 0;
        while (LINK_DATA !== 1'b1 && n < 400) begin
            @(posedge CORE_CLK);
            n++;
        end
    endtask : link_up

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // a hung handshake still ends the run
    initial begin
        #500us;
        n_fail++;
        close_out();
    end

    initial begin
        int n0, n, c, fc, lc;
        logic [31:0] v;
        logic [8:0] a, b;
        logic [7:0] p0, p1, p2;
        logic [13:0] s, r;
        foreach (mdl[i]) mdl[i] = REG_RESET;
        foreach (regs[i]) msk[regs[i]] = msks[i];
        repeat (12) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        // reset values and random writes
        foreach (regs[i]) rd(regs[i]);
        repeat (2) foreach (regs[i]) begin
            v = xs();
            wr(regs[i], v[7:0]);
            rd(regs[i]);
        end
        // strobe off, unmapped, misaligned
        PSTRB <= 4'h0;
        wr(IDX_LINK, 8'h5a);
        PSTRB <= 4'h1;
        apb(1'b0, 12'h000, 32'h0);
        chk(ev, 1'b1);
        apb(1'b1, {IDX_LINK, 2'b01}, 32'hff);
        chk(ev, 1'b1);
        rd(IDX_LINK);
        $display("test registers done");
        // power control; status read-only
        for (int i = 0; i < 8; i++) begin
            v = xs();
            SLEEP_PIN <= v[8];
            wr(IDX_POWER, (v[7:0] & MASK_POWER & 8'hfe) | {7'h0, i[0]});
            repeat (2) @(posedge CORE_CLK);
            chk({CHA_SLEEP, CHB_SLEEP, ADC_STANDBY, DEVICE_SLEEP},
                pwr_exp(mdl[IDX_POWER], v[8]));
            apb(1'b1, {2'b00, IDX_STATUS, 2'b00}, 32'hff);
            apb(1'b0, {2'b00, IDX_STATUS, 2'b00}, 32'h0);
            chk(rv, {28'h0, pwr_exp(mdl[IDX_POWER], v[8])});
        end
        $display("test power done");
        // sample enable rate for every divider code
        for (int i = 0; i < 4; i++) begin
            wr(IDX_CLKDIV, {i[1:0], 6'h00});
            repeat (2) @(posedge CORE_CLK);
            c = 0;
            repeat (8) begin
                @(posedge CORE_CLK);
                c += SAMPLE_EN;
            end
            chk(c, i == 2 ? 4 : i == 3 ? 2 : 8);
        end
        $display("test divider done");
        // idle codes, then test patterns
        wr(IDX_LINK, 8'h20);
        repeat (3) @(posedge CORE_CLK);
        a = {LANE_A_K, LANE_A_DATA};
        @(posedge CORE_CLK);
        b = {LANE_A_K, LANE_A_DATA};
        chk({a, b} == {1'b1, K28_5, 1'b0, IDLE_ALT} ||
            {a, b} == {1'b0, IDLE_ALT, 1'b1, K28_5}, 1);
        wr(IDX_LINK, 8'h00);
        repeat (3) @(posedge CORE_CLK);
        a = {LANE_A_K, LANE_A_DATA};
        @(posedge CORE_CLK);
        chk({a, LANE_A_K, LANE_A_DATA}, {2{1'b1, K28_5}});
        wr(IDX_LINK, {PAT_CLOCK, 6'h00});
        repeat (3) @(posedge CORE_CLK);
        chk(LANE_A_DATA, CLOCK_OCTET);
        wr(IDX_LINK, {PAT_ENCODED, 6'h00});
        repeat (3) @(posedge CORE_CLK);
        chk(LANE_B_DATA, ENC);
        wr(IDX_LINK, {PAT_PRBS, 6'h00});
        repeat (3) @(posedge CORE_CLK);
        p0 = LANE_A_DATA;
        @(posedge CORE_CLK);
        p1 = LANE_A_DATA;
        @(posedge CORE_CLK);
        p2 = LANE_A_DATA;
        chk(p0 != p1 || p1 != p2, 1);
        $display("test idle and patterns done");
        // ila length against the skip path
        link_up(8'h00, 8'h00, 8'h00, 8'h01, n0);
        chk(n0 < 4, 1);
        link_up(8'h03, OPF_40X, 8'h01, 8'h00, n);
        chk(n - n0, 32);
        link_up(8'h01, OPF_40X, 8'h01, 8'h00, n);
        chk(n - n0, 144);
        link_up(8'h00, OPF_40X, 8'h01, 8'h00, n);
        chk(n - n0, 72);
        $display("test ila done");
        // data phase: plain, flipped, transport
        v = xs();
        s = v[13:0];
        r = {<<{s}};
        CHA_SAMPLE <= s;
        CHB_SAMPLE <= ~s;
        repeat (6) @(posedge CORE_CLK);
        lane_chk(8'hff, s[13:6], {s[5:0], 2'b00});
        wr(IDX_LINK, 8'h08);
        repeat (6) @(posedge CORE_CLK);
        lane_chk(8'hff, r[13:6], {r[5:0], 2'b00});
        wr(IDX_LINK, 8'h10);
        repeat (6) @(posedge CORE_CLK);
        lane_chk(8'hc3, 8'h40, 8'h00);
        // two multiframes, both aligns on
        wr(IDX_LINK, 8'h06);
        repeat (4) @(posedge CORE_CLK);
        fc = n_fc;
        lc = n_lc;
        repeat (36) @(posedge CORE_CLK);
        chk(n_fc - fc, 16);
        chk(n_lc - lc, 2);
        $display("test data phase done");
        close_out();
    end
endmodule : testbench

bind apcl_config apcl_config_assertions chk_u (.*);
